//--- verilog/sph_consts.svh
`ifndef SPH_CONSTS_SVH
`define SPH_CONSTS_SVH

// Process image byte addresses of the emulation
`define SPH_IMG_BASE       10'h1f4
`define SPH_IMG_BYTES      6
// Control byte fields
`define SPH_CTL_REG_BIT    7
`define SPH_CTL_LEN_HI     6
`define SPH_CTL_LEN_LO     4
`define SPH_CTL_INIT_BIT   2
`define SPH_CTL_RXACK_BIT  1
`define SPH_CTL_TXREQ_BIT  0
// Status byte fields
`define SPH_STS_LEN_HI     6
`define SPH_STS_LEN_LO     4
`define SPH_STS_FULL_BIT   3
`define SPH_STS_INITA_BIT  2
`define SPH_STS_RXRDY_BIT  1
`define SPH_STS_TXACK_BIT  0
// Data set size
`define SPH_SET_MAX        3'h5
// Emulation station address
`define SPH_EMU_ADDR       7'h63
// Line defaults: 8 data bits, even parity, one stop bit
`define SPH_DEF_BAUD       19200
`define SPH_CLK_HZ         250000000
`define SPH_DEF_DIV        ((`SPH_CLK_HZ) / (`SPH_DEF_BAUD))
`define SPH_DEF_PAR_EN     1'b1
`define SPH_DEF_PAR_ODD    1'b0
`define SPH_FIFO_DEPTH     4

`endif

//--- verilog/sph_pkg.sv
package sph_pkg;
	typedef enum logic [1:0] {SPH_TX_IDLE, SPH_TX_LOAD} sph_txld_t;
	typedef enum logic [1:0] {SPH_RX_IDLE, SPH_RX_FILL, SPH_RX_WAIT}
		sph_rxst_t;
	typedef enum logic [1:0] {SPH_LN_IDLE, SPH_LN_DATA, SPH_LN_PAR,
		SPH_LN_STOP} sph_line_t;
endpackage

//--- verilog/sph_fifo.sv
`timescale 1ns/1ps
module sph_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input  wire logic             clk,
	input  wire logic             sys_rst,
	input  wire logic             ce,
	input  wire logic             flush,
	input  wire logic [WIDTH-1:0] inData,
	input  wire logic             inValid,
	output logic                  inReady,
	output logic      [WIDTH-1:0] outData,
	output logic                  outValid,
	input  wire logic             outReady
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wrPtr;
	logic [AW-1:0]    rdPtr;
	logic [AW:0]      count;
	logic             doWr;
	logic             doRd;

	assign inReady  = (count != (AW+1)'(DEPTH));
	assign outValid = (count != '0);
	assign outData  = mem[rdPtr];
	assign doWr     = inValid && inReady;
	assign doRd     = outValid && outReady;

	// Storage; no reset needed for data words
	always_ff @(posedge clk) begin
		if (ce && doWr) begin
			mem[wrPtr] <= inData;
		end
	end

	// Pointers and fill level; flush wins over traffic
	always_ff @(posedge clk) begin
		if (sys_rst || (ce && flush)) begin
			wrPtr <= '0;
			rdPtr <= '0;
			count <= '0;
		end else if (ce) begin
			if (doWr) begin
				wrPtr <= (wrPtr == AW'(DEPTH-1)) ? '0 : wrPtr + 1'b1;
			end
			if (doRd) begin
				rdPtr <= (rdPtr == AW'(DEPTH-1)) ? '0 : rdPtr + 1'b1;
			end
			count <= count + (AW+1)'(doWr) - (AW+1)'(doRd);
		end
	end
endmodule

//--- verilog/sph_port.sv
// How it works
// - Image has control or status byte plus five data bytes per direction.
// - Bytes sit at process image addresses 500 to 505 on both sides.
// - Control: bit7 select, bits6-4 send length, bit2 init, bit1 ack, bit0 req.
// - Status: bit7 zero, length, full flag, init done, rx toggle, tx ack.
// - Each send request toggle loads up to five output bytes into FIFO.
// - After loading, send done toggle is updated to report completion.
// - Place received set in data bytes, set length, then toggle ready.
// - No new received set until controller toggles its acknowledge.
// - While init is high: stop line, flush FIFOs, reload line settings.
// - Init done is asserted once initialization has finished.
// - Full flag while receive FIFO full; new characters then dropped.
// - Characters with parity, framing or overrun errors never stored.
// - Line defaults to 8 data bits, even parity, one stop, 19200 baud.
// - Baud divisor settable only with address 99, else fixed default.
// - Emulation active only if address reads 99 at reset.
// - Address is tens switch times ten plus units, sampled at reset.
// - With address 99 active, programming log-on is refused.
`timescale 1ns/1ps
`include "sph_consts.svh"
module sph_port #(
	parameter int DIV_W = 16,
	parameter int FIFO_DEPTH = `SPH_FIFO_DEPTH
) (
	input  wire logic             clk,
	input  wire logic             sys_rst,
	input  wire logic             ce,
	input  wire logic [3:0]       tensSwitch,
	input  wire logic [3:0]       unitsSwitch,
	input  wire logic [9:0]       imgAddr,
	input  wire logic             imgWrite,
	input  wire logic [7:0]       imgWrData,
	output logic      [7:0]       imgRdData,
	input  wire logic [DIV_W-1:0] cfgBaudDiv,
	input  wire logic             cfgParityEn,
	input  wire logic             cfgParityOdd,
	input  wire logic             rxPin,
	output logic                  txPin,
	output logic                  txEnable,
	output logic                  emuActive,
	output logic                  logonAllowed
);
	import sph_pkg::*;
	logic [7:0]       portControlByte;
	logic [7:0]       dataOut [5];
	logic [7:0]       dataIn [5];
	logic [2:0]       recvLength;
	logic             sendDoneToggle;
	logic             rxReadyToggle;
	logic             initDone;
	logic             addrTaken;
	logic [DIV_W-1:0] baudDiv;
	logic             parEn;
	logic             parOdd;
	logic [1:0]       rxSync;
	logic             rxLine;
	logic [7:0]       swSync1;
	logic [7:0]       swSync2;
	logic [6:0]       swAddr;
	logic             rxInReady;
	logic             rxFull;
	logic             sendReqToggle;
	logic             rxTakenAck;
	logic             initCmd;
	logic [2:0]       sendLen;
	logic             lineOn;
	assign sendReqToggle = portControlByte[`SPH_CTL_TXREQ_BIT];
	assign rxTakenAck    = portControlByte[`SPH_CTL_RXACK_BIT];
	assign initCmd       = portControlByte[`SPH_CTL_INIT_BIT];
	assign sendLen       = portControlByte[`SPH_CTL_LEN_HI:`SPH_CTL_LEN_LO];
	assign lineOn        = emuActive && !initCmd;
	assign rxFull        = !rxInReady;
	// Switch pins pass two flops; unreset, so they settle during reset
	always_ff @(posedge clk) begin
		if (ce) begin
			swSync1 <= {tensSwitch, unitsSwitch};
			swSync2 <= swSync1;
		end
	end
	// Tens digit times ten plus units, widened before the product
	assign swAddr = 7'(swSync2[7:4]) * 7'h0a + 7'(swSync2[3:0]);
	// Station address caught one edge after reset release
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			addrTaken    <= 1'b0;
			emuActive    <= 1'b0;
			logonAllowed <= 1'b0;
		end else if (ce && !addrTaken) begin
			addrTaken    <= 1'b1;
			emuActive    <= swAddr == `SPH_EMU_ADDR;
			// Switch holds 0..99; 0 is reserved, 99 locks log-on
			logonAllowed <= swAddr != `SPH_EMU_ADDR;
		end
	end
	// Output image writes from the controller program
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			portControlByte <= 8'h00;
			for (int i = 0; i < 5; i++) begin
				dataOut[i] <= 8'h00;
			end
		end else if (ce && imgWrite && emuActive) begin
			if (imgAddr == `SPH_IMG_BASE) begin
				portControlByte <= imgWrData;
			end
			for (int i = 0; i < 5; i++) begin
				if (imgAddr == `SPH_IMG_BASE + 10'(i + 1)) begin
					dataOut[i] <= imgWrData;
				end
			end
		end
	end
	// Input image read mux, registered
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			imgRdData <= 8'h00;
		end else if (ce) begin
			imgRdData <= 8'h00;
			if (emuActive && imgAddr == `SPH_IMG_BASE) begin
				imgRdData <= {1'b0, recvLength, rxFull, initDone,
					rxReadyToggle, sendDoneToggle};
			end
			for (int i = 0; i < 5; i++) begin
				if (emuActive && imgAddr == `SPH_IMG_BASE + 10'(i + 1)) begin
					imgRdData <= dataIn[i];
				end
			end
		end
	end
	// Line settings reload while init request is high
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			baudDiv  <= DIV_W'(`SPH_DEF_DIV);
			parEn    <= `SPH_DEF_PAR_EN;
			parOdd   <= `SPH_DEF_PAR_ODD;
			initDone <= 1'b0;
		end else if (ce) begin
			if (initCmd) begin
				// Rate only follows config at address 99
				baudDiv  <= emuActive ? cfgBaudDiv
					: DIV_W'(`SPH_DEF_DIV);
				parEn    <= cfgParityEn;
				parOdd   <= cfgParityOdd;
				initDone <= 1'b1;
			end else begin
				initDone <= 1'b0;
			end
		end
	end
	// Transmit FIFO fill from output data bytes
	logic       txInValid;
	logic       txInReady;
	logic [7:0] txOutData;
	logic       txOutValid;
	logic       txOutReady;
	logic [2:0] loadIdx;
	logic [2:0] loadCnt;
	sph_txld_t  txLd;
	assign txInValid = (txLd == SPH_TX_LOAD) && (loadIdx != loadCnt);
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			txLd           <= SPH_TX_IDLE;
			loadIdx        <= 3'h0;
			loadCnt        <= 3'h0;
			sendDoneToggle <= 1'b0;
		end else if (ce) begin
			unique case (txLd)
				SPH_TX_IDLE: begin
					// Pending while request differs from ack
					if (lineOn && sendReqToggle != sendDoneToggle) begin
						txLd    <= SPH_TX_LOAD;
						loadIdx <= 3'h0;
						loadCnt <= (sendLen > `SPH_SET_MAX) ? `SPH_SET_MAX
							: sendLen;
					end
				end
				SPH_TX_LOAD: begin
					if (initCmd) begin
						txLd <= SPH_TX_IDLE;
					end else if (loadIdx == loadCnt) begin
						sendDoneToggle <= sendReqToggle;
						txLd           <= SPH_TX_IDLE;
					end else if (txInReady) begin
						loadIdx <= loadIdx + 3'h1;
					end
				end
			endcase
		end
	end
	sph_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) txFifo (
		.clk      (clk),
		.sys_rst  (sys_rst),
		.ce       (ce),
		.flush    (initCmd),
		.inData   (dataOut[loadIdx]),
		.inValid  (txInValid),
		.inReady  (txInReady),
		.outData  (txOutData),
		.outValid (txOutValid),
		.outReady (txOutReady)
	);
	// Serial transmitter
	logic [DIV_W-1:0] txTick;
	logic [3:0]       txBit;
	logic [10:0]      txShift;
	logic [3:0]       txLen;
	assign txOutReady = lineOn && !txEnable;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			txPin    <= 1'b1;
			txEnable <= 1'b0;
			txTick   <= '0;
			txBit    <= 4'h0;
			txShift  <= 11'h7ff;
			txLen    <= 4'h0;
		end else if (ce) begin
			if (!lineOn) begin
				txPin    <= 1'b1;
				txEnable <= 1'b0;
			end else if (!txEnable && txOutValid) begin
				// Start, 8 data, optional parity, stop
				txShift  <= parEn ? {1'b1, ^txOutData ^ parOdd, txOutData, 1'b0}
					: {2'b11, txOutData, 1'b0};
				txLen    <= parEn ? 4'hb : 4'ha;
				txBit    <= 4'h0;
				txTick   <= '0;
				txEnable <= 1'b1;
			end else if (txEnable) begin
				txPin <= txShift[0];
				if (txTick == baudDiv - 1'b1) begin
					txTick  <= '0;
					txShift <= {1'b1, txShift[10:1]};
					txBit   <= txBit + 4'h1;
					if (txBit == txLen - 4'h1) begin
						txEnable <= 1'b0;
					end
				end else begin
					txTick <= txTick + 1'b1;
				end
			end
		end
	end
	// Receive pin synchroniser
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rxSync <= 2'b11;
		end else if (ce) begin
			rxSync <= {rxSync[0], rxPin};
		end
	end
	assign rxLine = rxSync[1];

	// Serial receiver; bad characters never reach the FIFO
	sph_line_t        rxSt;
	logic [DIV_W-1:0] rxTick;
	logic [2:0]       rxBitNo;
	logic [7:0]       rxShift;
	logic             rxParOk;
	logic             rxInValid;
	logic [7:0]       rxOutData;
	logic             rxOutValid;
	logic             rxOutReady;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rxSt      <= SPH_LN_IDLE;
			rxTick    <= '0;
			rxBitNo   <= 3'h0;
			rxShift   <= 8'h00;
			rxParOk   <= 1'b1;
			rxInValid <= 1'b0;
		end else if (ce) begin
			rxInValid <= 1'b0;
			if (!lineOn) begin
				rxSt <= SPH_LN_IDLE;
			end else if (rxSt == SPH_LN_IDLE) begin
				if (!rxLine) begin
					rxSt    <= SPH_LN_DATA;
					rxTick  <= DIV_W'(baudDiv + (baudDiv >> 1)); // Mid bit 0
					rxBitNo <= 3'h0;
				end
			end else if (rxTick != '0) begin
				rxTick <= rxTick - 1'b1;
			end else begin
				rxTick <= baudDiv - 1'b1;
				unique case (rxSt)
					SPH_LN_DATA: begin
						rxShift <= {rxLine, rxShift[7:1]};
						rxBitNo <= rxBitNo + 3'h1;
						if (rxBitNo == 3'h7) begin
							rxSt <= parEn ? SPH_LN_PAR : SPH_LN_STOP;
						end
					end
					SPH_LN_PAR: begin
						rxParOk <= (^rxShift ^ rxLine) == parOdd;
						rxSt    <= SPH_LN_STOP;
					end
					SPH_LN_STOP: begin
						// Framing, parity and full-FIFO drops
						rxInValid <= rxLine && (rxParOk || !parEn)
							&& rxInReady;
						rxParOk   <= 1'b1;
						rxSt      <= SPH_LN_IDLE;
					end
					default: rxSt <= SPH_LN_IDLE;
				endcase
			end
		end
	end
	sph_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) rxFifo (
		.clk      (clk),
		.sys_rst  (sys_rst),
		.ce       (ce),
		.flush    (initCmd),
		.inData   (rxShift),
		.inValid  (rxInValid),
		.inReady  (rxInReady),
		.outData  (rxOutData),
		.outValid (rxOutValid),
		.outReady (rxOutReady)
	);
	// Receive set assembly into input image
	sph_rxst_t rxAs;
	logic [2:0] fillIdx;
	assign rxOutReady = (rxAs == SPH_RX_FILL) && (fillIdx != `SPH_SET_MAX);
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rxAs          <= SPH_RX_IDLE;
			fillIdx       <= 3'h0;
			recvLength    <= 3'h0;
			rxReadyToggle <= 1'b0;
			for (int i = 0; i < 5; i++) begin
				dataIn[i] <= 8'h00;
			end
		end else if (ce) begin
			if (initCmd) begin
				rxAs <= SPH_RX_IDLE;
			end else begin
				unique case (rxAs)
					SPH_RX_IDLE: begin
						// Only when previous set acknowledged
						if (rxOutValid && rxTakenAck == rxReadyToggle) begin
							rxAs    <= SPH_RX_FILL;
							fillIdx <= 3'h0;
						end
					end
					SPH_RX_FILL: begin
						if (rxOutValid && fillIdx != `SPH_SET_MAX) begin
							dataIn[fillIdx] <= rxOutData;
							fillIdx         <= fillIdx + 3'h1;
						end else begin
							recvLength <= fillIdx;
							rxAs       <= SPH_RX_WAIT;
						end
					end
					SPH_RX_WAIT: begin
						rxReadyToggle <= !rxReadyToggle;
						rxAs          <= SPH_RX_IDLE;
					end
					default: rxAs <= SPH_RX_IDLE;
				endcase
			end
		end
	end
endmodule

//--- verif/sph_port_checker.sv
`timescale 1ns/1ps
module sph_port_checker (
	input wire logic       clk,
	input wire logic       sys_rst,
	input wire logic       ce,
	input wire logic [9:0] imgAddr,
	input wire logic       imgWrite,
	input wire logic [7:0] imgWrData,
	input wire logic [7:0] imgRdData,
	input wire logic       txPin,
	input wire logic       txEnable,
	input wire logic       emuActive,
	input wire logic       logonAllowed
);
	logic stsRd;
	logic outMap;

	// Status slot reads and addresses outside the emulation image
	assign stsRd = ce && !imgWrite && imgAddr == 10'h1f4;
	assign outMap = imgAddr < 10'h1f4 || imgAddr > 10'h1f9;

	default clocking cb @(posedge clk); endclocking

	// Reset leaves a quiet line, blank image, neither mode chosen
	property p_rst;
		disable iff (1'b0) (sys_rst && ce) |=> txPin && !txEnable
			&& imgRdData == 8'h00 && !emuActive && !logonAllowed;
	endproperty
	a_rst: assert property (p_rst)
		else $error("reset state wrong");

	// Emulation and programming log-on never together
	property p_excl;
		disable iff (sys_rst) !(emuActive && logonAllowed);
	endproperty
	a_excl: assert property (p_excl)
		else $error("emulation and log-on both on");

	// Mode captured once, then held until the next reset
	property p_latch;
		disable iff (sys_rst) (emuActive || logonAllowed)
			|=> $stable(emuActive) && $stable(logonAllowed);
	endproperty
	a_latch: assert property (p_latch)
		else $error("mode changed outside reset");

	// Line rests high while the driver is off
	property p_idle;
		disable iff (sys_rst) !txEnable |-> txPin;
	endproperty
	a_idle: assert property (p_idle)
		else $error("line low while driver off");

	// Unmapped bytes read as zero
	property p_unmap;
		disable iff (sys_rst) (ce && outMap) |=> imgRdData == 8'h00;
	endproperty
	a_unmap: assert property (p_unmap)
		else $error("unmapped read not zero");

	// Top status bit stays clear in process data mode
	property p_bit7;
		disable iff (sys_rst) stsRd |=> !imgRdData[7];
	endproperty
	a_bit7: assert property (p_bit7)
		else $error("status bit 7 set");

	// Receive length never above five bytes
	property p_len;
		disable iff (sys_rst) stsRd |=> imgRdData[6:4] <= 3'h5;
	endproperty
	a_len: assert property (p_len)
		else $error("receive length above five");

	// Init request answered within three status reads
	property p_init;
		disable iff (sys_rst) (ce && imgWrite && emuActive
			&& imgAddr == 10'h1f4 && imgWrData[2]) ##1 stsRd [*3]
			|=> imgRdData[2];
	endproperty
	a_init: assert property (p_init)
		else $error("init done missing");
endmodule

//--- verif/sph_serial_dev.sv
`timescale 1ns/1ps
module sph_serial_dev #(
	parameter int DIV = 8
) (
	input  wire logic clk,
	input  wire logic txPin,
	output logic      rxPin
);
	logic [7:0] got [$];
	int         bad = 0;
	logic [9:0] sh;

	initial rxPin = 1'b1;

	// Sample mid-bit from the start edge; parity and stop checked
	always begin
		@(negedge txPin);
		repeat (DIV / 2) @(posedge clk);
		for (int i = 0; i < 10; i++) begin
			repeat (DIV) @(posedge clk);
			sh[i] = txPin;
		end
		got.push_back(sh[7:0]);
		if (^sh[8:0] !== 1'b0 || sh[9] !== 1'b1)
			bad++;
	end

	// One frame, LSB first, even parity; badPar spoils the parity
	task automatic put(input logic [7:0] b, input logic badPar);
		logic [10:0] f;
		f = {1'b1, ^b ^ badPar, b, 1'b0};
		@(posedge clk);
		for (int i = 0; i < 11; i++) begin
			#1 rxPin = f[i];
			repeat (DIV) @(posedge clk);
		end
	endtask
endmodule

//--- verif/sph_port_tb.sv
`timescale 1ns/1ps
module sph_port_tb;
	localparam int DIV = 8;
	localparam logic [9:0] CTL = 10'h1f4;
	logic       clk = 1'b0;
	logic       sys_rst = 1'b1;
	logic       ce = 1'b1;
	logic [3:0] tens = 4'h9;
	logic [3:0] units = 4'h9;
	logic [9:0] imgAddr = 10'h000;
	logic       imgWrite = 1'b0;
	logic [7:0] imgWrData = 8'h00;
	logic [7:0] imgRdData;
	logic       rxPin;
	logic       txPin;
	logic       txEnable;
	logic       emuActive;
	logic       logonAllowed;
	int         fail_count = 0;
	int         cmp_count = 0;
	int         seed = 62;
	logic [7:0] ctl = 8'h00;
	logic [7:0] sts;
	logic [7:0] d;
	logic [7:0] exp [$];
	logic [7:0] rxExp [$];

	always #2 clk = ~clk;

	sph_port u_dut (
		.clk(clk), .sys_rst(sys_rst), .ce(ce),
		.tensSwitch(tens), .unitsSwitch(units),
		.imgAddr(imgAddr), .imgWrite(imgWrite),
		.imgWrData(imgWrData), .imgRdData(imgRdData),
		.cfgBaudDiv(16'(DIV)), .cfgParityEn(1'b1),
		.cfgParityOdd(1'b0), .rxPin(rxPin), .txPin(txPin),
		.txEnable(txEnable), .emuActive(emuActive),
		.logonAllowed(logonAllowed)
	);

	sph_serial_dev #(.DIV(DIV)) u_dev (
		.clk(clk), .txPin(txPin), .rxPin(rxPin)
	);

	task automatic chk(input logic [7:0] got, input logic [7:0] want);
		cmp_count++;
		if (got !== want) begin
			fail_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, want);
		end
	endtask

	task automatic conclude;
		if (fail_count == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Image bus: one byte per access, write strobe for one cycle
	task automatic wr(input logic [9:0] a, input logic [7:0] v);
		@(posedge clk);
		#1 imgAddr = a;
		imgWrite = 1'b1;
		imgWrData = v;
		@(posedge clk);
		#1 imgWrite = 1'b0;
	endtask

	task automatic rd(input logic [9:0] a, output logic [7:0] v);
		@(posedge clk);
		#1 imgAddr = a;
		@(posedge clk);
		#1 v = imgRdData;
	endtask

	// Poll a status bit; a long wait ends the run
	task automatic waitSts(input int b, input logic v);
		for (int i = 0; i < 3000; i++) begin
			rd(CTL, sts);
			if (sts[b] === v)
				return;
		end
		fail_count++;
		conclude();
	endtask

	// Fill all five data bytes, then toggle the send request
	task automatic sendSet(input int n);
		for (int i = 0; i < 5; i++) begin
			d = 8'($random(seed));
			wr(CTL + 10'(i + 1), d);
			if (i < n)
				exp.push_back(d);
		end
		ctl = {1'b0, 3'(n), 1'b0, ctl[2:1], ~ctl[0]};
		wr(CTL, ctl);
		waitSts(0, ctl[0]);
	endtask

	task automatic takeSet(input int n);
		waitSts(1, ~ctl[1]);
		chk({5'h00, sts[6:4]}, 8'(n));
		for (int i = 0; i < n; i++) begin
			rd(CTL + 10'(i + 1), d);
			chk(d, rxExp.pop_front());
		end
	endtask

	task automatic ack;
		ctl[1] = ~ctl[1];
		wr(CTL, ctl);
	endtask

	initial begin
		repeat (10) @(posedge clk);
		#1 sys_rst = 1'b0;
		repeat (2) @(posedge clk);
		#1 chk({6'h00, emuActive, logonAllowed}, 8'h02);
		rd(10'h1fa, d);
		chk(d, 8'h00);
		// Init loads the short divisor used for the rest of the run
		ctl = 8'h04;
		wr(CTL, ctl);
		waitSts(2, 1'b1);
		ctl = 8'h00;
		wr(CTL, ctl);
		waitSts(2, 1'b0);
		// Short freeze of the clock enable while idle
		@(posedge clk);
		#1 ce = 1'b0;
		repeat (3) @(posedge clk);
		#1 ce = 1'b1;
		// Full set, single byte, length seven clamped to five
		sendSet(5);
		sendSet(1);
		sendSet(7);
		for (int i = 0; i < 5000 && u_dev.got.size() < 11; i++)
			@(posedge clk);
		chk(8'(u_dev.got.size()), 8'h0b);
		while (exp.size() > 0 && u_dev.got.size() > 0)
			chk(u_dev.got.pop_front(), exp.pop_front());
		chk(8'(u_dev.bad), 8'h00);
		// First set held unacknowledged while more characters arrive
		d = 8'($random(seed));
		rxExp.push_back(d);
		u_dev.put(d, 1'b0);
		takeSet(1);
		for (int i = 0; i < 6; i++) begin
			d = 8'($random(seed));
			u_dev.put(d, i == 1);
			if (i != 1 && i < 5)
				rxExp.push_back(d);
		end
		rd(CTL, sts);
		chk(8'(sts[3]), 8'h01);
		chk(8'(sts[1] ^ ctl[1]), 8'h01);
		ack();
		takeSet(4);
		ack();
		rd(CTL, sts);
		chk(8'(sts[3]), 8'h00);
		// Restart at a programming address: emulation stays off
		@(posedge clk);
		#1 tens = 4'h1;
		units = 4'h8;
		sys_rst = 1'b1;
		repeat (3) @(posedge clk);
		#1 sys_rst = 1'b0;
		repeat (2) @(posedge clk);
		#1 chk({6'h00, emuActive, logonAllowed}, 8'h01);
		wr(CTL, 8'h05);
		rd(CTL, sts);
		chk(sts, 8'h00);
		chk({7'h00, txEnable}, 8'h00);
		conclude();
	end
endmodule

bind sph_port sph_port_checker u_chk (
	.clk(clk), .sys_rst(sys_rst), .ce(ce), .imgAddr(imgAddr),
	.imgWrite(imgWrite), .imgWrData(imgWrData),
	.imgRdData(imgRdData), .txPin(txPin), .txEnable(txEnable),
	.emuActive(emuActive), .logonAllowed(logonAllowed)
);
